// >>> rtl/wss_sequencer.sv
// Per-channel segment sequencer: walks the step table, emits sample addresses
// Assumes segment start/length come from a lookup fed by segment number,
// answered combinationally; all inputs are synchronous to ref_clk_i
`timescale 1ns/100ps
`include "wss_defs.svh"
module wss_sequencer #(
  parameter int STEP_W = `WSS_STEP_W,
  parameter int DLY_W  = `WSS_DLY_W
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    tbl_wr_en_i,     // Table write strobe
  input  wire logic [STEP_W-1:0]       tbl_wr_addr_i,   // Table write index
  input  wire wss_pkg::wss_entry_s     tbl_wr_data_i,   // Table entry
  input  wire logic [STEP_W-1:0]       tbl_last_i,      // Index of last step
  input  wire logic                    tbl_loaded_i,    // Table complete
  input  wire logic                    run_i,           // Sequenced playback request
  input  wire wss_pkg::wss_adv_e       adv_mode_i,      // Advance mode
  input  wire wss_pkg::wss_run_e       run_mode_i,      // Run mode
  input  wire wss_pkg::wss_src_e       trig_src_i,      // Trigger source
  input  wire logic [DLY_W-1:0]        trig_delay_i,    // Trigger delay, cycles
  input  wire logic                    external_trigger_input_i,
  input  wire logic                    manual_trigger_button_i,
  input  wire logic                    bus_trigger_i,   // Remote trigger command
  input  wire wss_pkg::wss_seg_s       seg_info_i,      // Geometry of seg_sel_o
  output logic [`WSS_SEG_W-1:0]        seg_sel_o,       // Segment looked up
  output logic [`WSS_ADDR_W-1:0]       samp_addr_o,     // Sample memory address
  output logic                         samp_valid_o,    // Address valid
  output logic [STEP_W-1:0]            cur_step_o,      // Current step index
  output logic                         waiting_o,       // Holding for trigger
  output logic                         conflict_o       // Settings conflict error
);
  import wss_pkg::*;

  initial begin
    if (STEP_W != `WSS_STEP_W || DLY_W < 1) begin
      $error("wss_sequencer: unsupported parameter value");
    end
  end

  // Sequencer states
  typedef enum logic [1:0] {
    WSS_ST_IDLE  = 2'b00,
    WSS_ST_FETCH = 2'b01,
    WSS_ST_PLAY  = 2'b10,
    WSS_ST_HOLD  = 2'b11
  } wss_state_e;

  wss_state_e             state_q;      // Main state
  wss_entry_s             entry;        // Entry read from table
  wss_entry_s             cur_q;        // Entry being played
  logic [STEP_W-1:0]      rd_idx;       // Table read index
  logic [STEP_W-1:0]      nxt_idx;      // Following step index
  logic [`WSS_ADDR_W-1:0] offs_q;       // Offset inside segment
  logic [`WSS_RPT_W-1:0]  rpt_q;        // Repeats left
  logic                   seg_end;      // Last sample of segment
  logic                   step_end;     // Last sample of last repeat
  logic                   pend_q;       // Accepted trigger pending
  logic                   trig_raw;     // Trigger from selected source
  logic                   trig_fire;    // Trigger after delay
  logic [DLY_W-1:0]       dly_q;        // Delay countdown
  logic                   dly_act_q;    // Delay running
  logic                   conflict;     // Illegal mode combination
  logic                   hold_here;    // Step must wait for trigger
  logic                   ok_run;       // Playback allowed

  // Table memory, read one cycle ahead
  wss_table_mem #(
    .DEPTH_LOG2 (STEP_W),
    .WIDTH      (`WSS_ENTRY_W)
  ) u_tbl (
    .ref_clk_i  (ref_clk_i),
    .wr_en_i    (tbl_wr_en_i),
    .wr_addr_i  (tbl_wr_addr_i),
    .wr_data_i  (tbl_wr_data_i),
    .rd_addr_i  (rd_idx),
    .rd_data_o  (entry)
  );

  // Mode legality check
  always_comb begin
    conflict = 1'b0;
    unique case (adv_mode_i)
      WSS_ADV_AUTO:   conflict = (run_mode_i == WSS_RUN_BURST);
      WSS_ADV_STEP:   conflict = (run_mode_i != WSS_RUN_CONT);
      WSS_ADV_SINGLE: conflict = (run_mode_i != WSS_RUN_TRIG);
      WSS_ADV_MIXED:  conflict = (run_mode_i != WSS_RUN_CONT);
    endcase
    if (trig_src_i == WSS_SRC_MIXED || trig_src_i == WSS_SRC_RSVD) begin
      conflict = 1'b1;
    end
  end

  assign ok_run = run_i && tbl_loaded_i && !conflict;

  // Trigger source select
  always_comb begin
    unique case (trig_src_i)
      WSS_SRC_EXT: trig_raw = external_trigger_input_i | manual_trigger_button_i;
      WSS_SRC_BUS: trig_raw = bus_trigger_i;
      default:     trig_raw = 1'b0;
    endcase
  end

  // Trigger delay, zero passes through
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dly_q     <= '0;
      dly_act_q <= 1'b0;
    end else if (trig_raw && !dly_act_q && trig_delay_i != '0) begin
      dly_q     <= trig_delay_i - DLY_W'(`WSS_DLY_ONE);
      dly_act_q <= 1'b1;
    end else if (dly_act_q && dly_q != '0) begin
      dly_q <= dly_q - DLY_W'(`WSS_DLY_ONE);
    end else begin
      dly_act_q <= 1'b0;
    end
  end

  assign trig_fire = (trig_raw && trig_delay_i == '0) || (dly_act_q && dly_q == '0);

  // Boundary and step flags
  assign seg_end  = (offs_q + `WSS_ADDR_ONE == seg_info_i.length);
  assign step_end = seg_end && (rpt_q <= `WSS_RPT_ONE);
  assign nxt_idx  = (cur_step_o == tbl_last_i) ? `WSS_STEP_ZERO
                                               : cur_step_o + 1'b1;
  assign rd_idx   = (state_q == WSS_ST_PLAY || state_q == WSS_ST_HOLD) ? nxt_idx
                                                                       : `WSS_STEP_ZERO;

  // Step needs a trigger before leaving
  always_comb begin
    unique case (adv_mode_i)
      WSS_ADV_AUTO:   hold_here = 1'b0;
      WSS_ADV_STEP:   hold_here = 1'b1;
      WSS_ADV_SINGLE: hold_here = 1'b1;
      WSS_ADV_MIXED:  hold_here = cur_q.advance;
    endcase
  end

  // Pending trigger; each trigger is spent on at most one advance
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
    end else if (state_q == WSS_ST_IDLE || state_q == WSS_ST_FETCH) begin
      pend_q <= 1'b0;
    end else if (state_q == WSS_ST_HOLD) begin
      pend_q <= trig_fire;            // Pending one used on leaving, new one kept
    end else if (step_end && hold_here) begin
      pend_q <= pend_q && trig_fire;  // used here; keep only a second trigger
    end else if (trig_fire) begin
      pend_q <= 1'b1;
    end else if (step_end && state_q == WSS_ST_PLAY) begin
      pend_q <= 1'b0;
    end
  end

  // Main walk through the table
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q    <= WSS_ST_IDLE;
      cur_q      <= '0;
      cur_step_o <= '0;
      offs_q     <= `WSS_ADDR_ZERO;
      rpt_q      <= `WSS_RPT_ZERO;
    end else if (!ok_run) begin
      state_q    <= WSS_ST_IDLE;
      cur_step_o <= '0;
    end else begin
      unique case (state_q)
        WSS_ST_IDLE: begin
          state_q <= WSS_ST_FETCH; // Table read of step zero
        end
        WSS_ST_FETCH: begin
          cur_q      <= entry;
          cur_step_o <= `WSS_STEP_ZERO;
          rpt_q      <= entry.repeats;
          offs_q     <= `WSS_ADDR_ZERO;
          state_q    <= WSS_ST_PLAY;
        end
        WSS_ST_PLAY: begin
          if (!seg_end) begin
            offs_q <= offs_q + `WSS_ADDR_ONE;
          end else if (!step_end) begin
            offs_q <= `WSS_ADDR_ZERO;
            rpt_q  <= rpt_q - `WSS_RPT_ONE;
          end else if (!hold_here || pend_q || trig_fire) begin
            cur_q      <= entry;
            cur_step_o <= nxt_idx;
            rpt_q      <= entry.repeats;
            offs_q     <= `WSS_ADDR_ZERO;
          end else if (adv_mode_i == WSS_ADV_SINGLE) begin
            state_q <= WSS_ST_HOLD;
          end else begin
            offs_q <= `WSS_ADDR_ZERO;
            rpt_q  <= cur_q.repeats;
          end
        end
        WSS_ST_HOLD: begin
          if (pend_q) begin
            cur_q      <= entry;
            cur_step_o <= nxt_idx;
            rpt_q      <= entry.repeats;
            offs_q     <= `WSS_ADDR_ZERO;
            state_q    <= WSS_ST_PLAY;
          end
        end
      endcase
    end
  end

  assign seg_sel_o = cur_q.segment;

  // Registered outputs
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      samp_addr_o  <= `WSS_ADDR_ZERO;
      samp_valid_o <= 1'b0;
      waiting_o    <= 1'b0;
      conflict_o   <= 1'b0;
    end else begin
      samp_addr_o  <= seg_info_i.start + offs_q;
      samp_valid_o <= ok_run && state_q == WSS_ST_PLAY;
      waiting_o    <= ok_run && state_q == WSS_ST_HOLD;
      conflict_o   <= run_i && conflict;
    end
  end
endmodule : wss_sequencer

// >>> rtl/wss_defs.svh
// Named constants for the waveform segment sequencer
// Assumes inclusion by bare name from rtl files
`ifndef WSS_DEFS_SVH
`define WSS_DEFS_SVH
`define WSS_STEP_W      6
`define WSS_SEG_W       8
`define WSS_RPT_W       16
`define WSS_ADDR_W      20
`define WSS_SAMP_W      16
`define WSS_ENTRY_W     45
`define WSS_STEP_ZERO   6'h00
`define WSS_RPT_ONE     16'h0001
`define WSS_RPT_ZERO    16'h0000
`define WSS_ADDR_ONE    20'h0_0001
`define WSS_ADDR_ZERO   20'h0_0000
`define WSS_SAMP_ZERO   16'h0000
`define WSS_DLY_W       16
`define WSS_DLY_ZERO    16'h0000
`define WSS_DLY_ONE     16'h0001
`endif

// >>> rtl/wss_pkg.sv
// Types shared by the waveform segment sequencer files
// Assumes wss_defs.svh is on the include path
`include "wss_defs.svh"
package wss_pkg;
  // Advance modes
  typedef enum logic [1:0] {
    WSS_ADV_AUTO   = 2'b00,
    WSS_ADV_STEP   = 2'b01,
    WSS_ADV_SINGLE = 2'b10,
    WSS_ADV_MIXED  = 2'b11
  } wss_adv_e;
  // Run modes
  typedef enum logic [1:0] {
    WSS_RUN_CONT  = 2'b00,
    WSS_RUN_TRIG  = 2'b01,
    WSS_RUN_GATED = 2'b10,
    WSS_RUN_BURST = 2'b11
  } wss_run_e;
  // Trigger sources
  typedef enum logic [1:0] {
    WSS_SRC_EXT   = 2'b00,
    WSS_SRC_BUS   = 2'b01,
    WSS_SRC_MIXED = 2'b10,
    WSS_SRC_RSVD  = 2'b11
  } wss_src_e;
  // One sequence table entry
  typedef struct packed {
    logic [`WSS_STEP_W-1:0] link;
    logic [`WSS_SEG_W-1:0]  segment;
    logic [`WSS_RPT_W-1:0]  repeats;
    logic                   advance;
    logic [`WSS_SEG_W-1:0]  pad;
    logic [5:0]             pad2;
  } wss_entry_s;
  // Segment geometry answer
  typedef struct packed {
    logic [`WSS_ADDR_W-1:0] start;
    logic [`WSS_ADDR_W-1:0] length;
  } wss_seg_s;
endpackage : wss_pkg

// >>> rtl/wss_table_mem.sv
// Sequence table memory, one entry per step
// Assumes one write port from host, registered read
`timescale 1ns/100ps
module wss_table_mem #(
  parameter int DEPTH_LOG2 = 6,
  parameter int WIDTH      = 45
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  wr_en_i,
  input  wire logic [DEPTH_LOG2-1:0] wr_addr_i,
  input  wire logic [WIDTH-1:0]      wr_data_i,
  input  wire logic [DEPTH_LOG2-1:0] rd_addr_i,
  output logic      [WIDTH-1:0]      rd_data_o
);
  logic [WIDTH-1:0] mem_q [2**DEPTH_LOG2]; // Storage array

  // Host write port
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read port
  always_ff @(posedge ref_clk_i) begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule : wss_table_mem

// >>> bench/wss_seg_model.sv
// Segment memory geometry model answering the sequencer lookups
// Assumes a combinational answer for the segment that is currently selected
`timescale 1ns/100ps
`include "wss_defs.svh"
module wss_seg_model (
  input  wire logic [`WSS_SEG_W-1:0] seg_sel_i,  // Segment looked up
  output wss_pkg::wss_seg_s          seg_info_o  // Start and length answer
);
  import wss_pkg::*;
  // Each segment has its own region; lengths differ so boundaries show
  always_comb begin
    seg_info_o.start  = {4'h0, seg_sel_i, 8'h00};
    seg_info_o.length = {12'h000, seg_sel_i} + 20'h0_0002;
  end
endmodule : wss_seg_model

// >>> bench/wss_checker.sv
// Port checker for the segment sequencer
// Assumes it is bound onto every sequencer instance
`timescale 1ns/100ps
module wss_checker
  import wss_pkg::*;
(
  input wire logic     ref_clk_i,
  input wire logic     rst_b_i,
  input wire logic     tbl_loaded_i,
  input wire logic     run_i,
  input wire wss_adv_e adv_mode_i,
  input wire wss_run_e run_mode_i,
  input wire wss_src_e trig_src_i,
  input wire logic     samp_valid_o,
  input wire logic     conflict_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_auto_burst_bad: assert property (run_i && adv_mode_i == WSS_ADV_AUTO &&
    run_mode_i == WSS_RUN_BURST |=> conflict_o) else $error("burst accepted in auto");
  a_step_run_bad: assert property (run_i && adv_mode_i == WSS_ADV_STEP &&
    run_mode_i != WSS_RUN_CONT |=> conflict_o) else $error("stepped run mode accepted");
  a_single_run_bad: assert property (run_i && adv_mode_i == WSS_ADV_SINGLE &&
    run_mode_i != WSS_RUN_TRIG |=> conflict_o) else $error("single run mode accepted");
  a_mixed_run_bad: assert property (run_i && adv_mode_i == WSS_ADV_MIXED &&
    run_mode_i != WSS_RUN_CONT |=> conflict_o) else $error("mixed run mode accepted");
  a_src_mixed_bad: assert property (run_i && trig_src_i == WSS_SRC_MIXED
    |=> conflict_o) else $error("mixed source accepted");
  a_auto_legal_ok: assert property (run_i && adv_mode_i == WSS_ADV_AUTO &&
    run_mode_i == WSS_RUN_CONT && trig_src_i == WSS_SRC_EXT |=> !conflict_o)
    else $error("legal auto setting refused");
  a_start_latency: assert property ($rose(run_i) && tbl_loaded_i && !samp_valid_o &&
    adv_mode_i == WSS_ADV_AUTO && run_mode_i == WSS_RUN_CONT && trig_src_i == WSS_SRC_EXT
    |-> ##[2:4] samp_valid_o) else $error("playback did not start");
  a_auto_gapless: assert property (samp_valid_o && run_i && adv_mode_i == WSS_ADV_AUTO &&
    run_mode_i == WSS_RUN_CONT |=> samp_valid_o) else $error("gap in auto stream");
  a_unloaded_quiet: assert property (!tbl_loaded_i && !samp_valid_o
    |=> !samp_valid_o) else $error("playback without table");
  a_reset_quiet: assert property ($rose(rst_b_i) |-> !samp_valid_o && !conflict_o)
    else $error("outputs active after reset");
  c_conflict: cover property (conflict_o);
  c_play: cover property ($rose(samp_valid_o));
  c_stop: cover property ($fell(samp_valid_o));
endmodule : wss_checker
bind wss_sequencer wss_checker wss_checker_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .tbl_loaded_i(tbl_loaded_i), .run_i(run_i), .adv_mode_i(adv_mode_i),
  .run_mode_i(run_mode_i), .trig_src_i(trig_src_i), .samp_valid_o(samp_valid_o),
  .conflict_o(conflict_o));

// >>> bench/wss_sequencer_bench.sv
// Self-checking bench for the segment sequencer
// Assumes the segment model answers lookups; inputs change on falling edges
`timescale 1ns/100ps
`include "wss_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module wss_sequencer_bench;
  import wss_pkg::*;
  logic ref_clk_i = 0, rst_b_i = 0, tbl_wr_en_i = 0, tbl_loaded_i = 0, run_i = 0;
  logic ext_i = 0, man_i = 0, bus_i = 0, samp_valid_o, waiting_o, conflict_o;
  logic [15:0] dly_i = 16'h0000;
  logic [5:0] tbl_wr_addr_i = 6'h00, tbl_last_i = 6'h02, cur_step_o;
  wss_entry_s tbl_wr_data_i = '0;
  wss_adv_e adv_mode_i = WSS_ADV_AUTO;
  wss_run_e run_mode_i = WSS_RUN_CONT;
  wss_src_e trig_src_i = WSS_SRC_EXT;
  wss_seg_s seg_info;
  logic [7:0] seg_sel_o, segs[3] = '{8'h02, 8'h01, 8'h03};
  logic [15:0] rpts[3] = '{16'h0002, 16'h0003, 16'h0001};
  logic [19:0] samp_addr_o, exp_q[$];
  int fails = 0, num_checks = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  wss_sequencer wss_sequencer_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .tbl_wr_en_i(tbl_wr_en_i), .tbl_wr_addr_i(tbl_wr_addr_i), .tbl_wr_data_i(tbl_wr_data_i),
    .tbl_last_i(tbl_last_i), .tbl_loaded_i(tbl_loaded_i), .run_i(run_i),
    .adv_mode_i(adv_mode_i), .run_mode_i(run_mode_i), .trig_src_i(trig_src_i),
    .trig_delay_i(dly_i), .external_trigger_input_i(ext_i),
    .manual_trigger_button_i(man_i), .bus_trigger_i(bus_i), .seg_info_i(seg_info),
    .seg_sel_o(seg_sel_o), .samp_addr_o(samp_addr_o), .samp_valid_o(samp_valid_o),
    .cur_step_o(cur_step_o), .waiting_o(waiting_o), .conflict_o(conflict_o));
  wss_seg_model wss_seg_model_inst (.seg_sel_i(seg_sel_o), .seg_info_o(seg_info));
  // Prints counts and verdict, then stops
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // Sets modes and requests playback
  task automatic start(input wss_adv_e a, input wss_run_e r, input wss_src_e s);
    adv_mode_i = a;
    run_mode_i = r;
    trig_src_i = s;
    run_i = 1;
  endtask : start
  // Drops the request and lets the block settle
  task automatic stop();
    run_i = 0;
    repeat (10) @(negedge ref_clk_i);
  endtask : stop
  // Cuts a hang short
  initial begin
    #100000;
    fails++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rst_b_i = 1;
    for (int i = 0; i < 3; i++) begin
      tbl_wr_data_i = '{link: 6'(i), segment: segs[i], repeats: rpts[i],
                        advance: 1'(i == 1), pad: 8'h00, pad2: 6'h00};
      tbl_wr_addr_i = 6'(i);
      tbl_wr_en_i = 1;
      @(negedge ref_clk_i);
    end
    tbl_wr_en_i = 0;
    start(WSS_ADV_AUTO, WSS_RUN_CONT, WSS_SRC_EXT);
    repeat (3) @(negedge ref_clk_i);
    `CHK("idle valid", 1'b0, samp_valid_o)
    tbl_loaded_i = 1;
    // Two passes of the table, every repeat and every offset in order
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 3; s++)
        for (int k = 0; k < rpts[s]; k++)
          for (int o = 0; o < segs[s] + 2; o++) exp_q.push_back({4'h0, segs[s], 8'h00} + 20'(o));
    for (int w = 0; w < 20 && samp_valid_o !== 1'b1; w++) @(negedge ref_clk_i);
    foreach (exp_q[i]) begin
      `CHK("stream addr", exp_q[i], samp_addr_o)
      `CHK("stream valid", 1'b1, samp_valid_o)
      @(negedge ref_clk_i);
    end
    stop();
    // Every advance and run mode pairing
    for (int a = 0; a < 4; a++)
      for (int r = 0; r < 4; r++) begin
        start(wss_adv_e'(a), wss_run_e'(r), WSS_SRC_EXT);
        repeat (3) @(negedge ref_clk_i);
        `CHK("conflict", 1'((a == 0) ? (r == 3) : (a == 2) ? (r != 1) : (r != 0)), conflict_o)
        stop();
      end
    start(WSS_ADV_AUTO, WSS_RUN_CONT, WSS_SRC_MIXED);
    repeat (3) @(negedge ref_clk_i);
    `CHK("mixed source", 1'b1, conflict_o)
    stop();
    // Stepped on bus source: hardware triggers ignored, bus trigger advances
    start(WSS_ADV_STEP, WSS_RUN_CONT, WSS_SRC_BUS);
    repeat (30) @(negedge ref_clk_i);
    `CHK("step hold", 6'h00, cur_step_o)
    {ext_i, man_i} = 2'b11;
    @(negedge ref_clk_i);
    {ext_i, man_i} = 2'b00;
    repeat (30) @(negedge ref_clk_i);
    `CHK("hw ignored", 6'h00, cur_step_o)
    bus_i = 1;
    @(negedge ref_clk_i);
    bus_i = 0;
    repeat (30) @(negedge ref_clk_i);
    `CHK("step moved", 6'h01, cur_step_o)
    stop();
    // Single: one pass, then hold until triggered
    start(WSS_ADV_SINGLE, WSS_RUN_TRIG, WSS_SRC_EXT);
    repeat (40) @(negedge ref_clk_i);
    `CHK("single hold", 1'b1, waiting_o)
    ext_i = 1;
    @(negedge ref_clk_i);
    ext_i = 0;
    for (int w = 0; w < 20 && samp_valid_o !== 1'b1; w++) @(negedge ref_clk_i);
    `CHK("single play", 1'b1, samp_valid_o)
    `CHK("segment", segs[1], seg_sel_o)
    repeat (40) @(negedge ref_clk_i);
    `CHK("one advance", 6'h01, cur_step_o)
    `CHK("single rehold", 1'b1, waiting_o)
    // Delayed trigger: still holding just after the delay has run out, before the step advances
    dly_i = 16'h0008;
    ext_i = 1;
    @(negedge ref_clk_i);
    ext_i = 0;
    repeat (8) @(negedge ref_clk_i);
    `CHK("delay hold", 1'b1, waiting_o)
    for (int w = 0; w < 20 && samp_valid_o !== 1'b1; w++) @(negedge ref_clk_i);
    `CHK("delayed step", 6'h02, cur_step_o)
    stop();
    final_report();
  end
endmodule : wss_sequencer_bench
